/* File: logic/prog_io_pkg.sv */
// Constants and types shared by the programmable I/O cell bank
// Behaviour
// - Input, output and enable register sections
// - Input register samples pad, else bypass
// - Output register optional, else core data passes
// - Freeze latch holds unregistered selected inputs
// - One freeze control for the whole bank
// - Hold-input control keeps core input value
// - Before configuration: high impedance, pull-up on
// - User settings only after configuration completes
// - Unused pins: input blocked, pull-up off
// - Per-pin bit selects pull-up or none
// - Registered inputs ignore the freeze latch
`default_nettype none

package prog_io_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int unsigned NUM_PINS = 8;
  localparam int unsigned ADDR_W   = 8;
  localparam int unsigned DATA_W   = 32;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] OFS_CTRL    = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_USED    = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IN_SEL  = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_OUT_SEL = 8'h0C;
  localparam logic [ADDR_W-1:0] OFS_OE_SEL  = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_PULL    = 8'h14;
  localparam logic [ADDR_W-1:0] OFS_FRZ_SEL = 8'h18;
  localparam logic [ADDR_W-1:0] OFS_PAD_IN  = 8'h1C;
  localparam logic [ADDR_W-1:0] OFS_STATUS  = 8'h20;

  // ----------------------------------------------------------------
  // Field positions and reset values
  // ----------------------------------------------------------------
  localparam int unsigned CTRL_DONE_BIT   = 0;
  localparam int unsigned CTRL_FREEZE_BIT = 1;
  localparam int unsigned STAT_DONE_BIT   = 0;
  localparam logic [NUM_PINS-1:0] RST_SEL  = 8'h00;
  localparam logic [NUM_PINS-1:0] RST_PULL = 8'hFF;

  // Configuration phase of the bank
  typedef enum logic [0:0] {
    PH_PRECONFIG = 1'b0,
    PH_USER      = 1'b1
  } cfg_phase_t;

endpackage

`default_nettype wire

/* File: logic/prog_io_pin.sv */
// One programmable I/O cell between core and pad
`default_nettype none

module prog_io_pin
  import prog_io_pkg::*;
(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic configured,
  input  wire logic used,
  input  wire logic in_reg_sel,
  input  wire logic out_reg_sel,
  input  wire logic oe_reg_sel,
  input  wire logic pullup_sel,
  input  wire logic freeze_sel,
  input  wire logic freeze,
  input  wire logic hold_input,
  input  wire logic in_tick,
  input  wire logic out_tick,
  input  wire logic clock_enable,
  input  wire logic pad_in,
  input  wire logic d_out,
  input  wire logic oe_core,
  output logic      d_in,
  output logic      pad_out,
  output logic      pad_oe,
  output logic      pad_pullup
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic in_reg_q, in_reg_d;
  logic out_reg_q, out_reg_d;
  logic oe_reg_q, oe_reg_d;
  logic d_in_q, d_in_d;
  logic pad_out_q, pad_out_d;
  logic pad_oe_q, pad_oe_d;
  logic pull_q, pull_d;
  logic active;
  logic frozen;

  // Next values of the three register sections and the pad side
  always_comb begin
    active    = configured & used;
    frozen    = freeze & freeze_sel & ~in_reg_sel;
    in_reg_d  = in_reg_q;
    out_reg_d = out_reg_q;
    oe_reg_d  = oe_reg_q;
    // Registers move only on their own clock with enable high
    if (in_tick && clock_enable) begin
      in_reg_d = pad_in;
    end
    if (out_tick && clock_enable) begin
      out_reg_d = d_out;
      oe_reg_d  = oe_core;
    end
    // d_in_q doubles as the freeze latch, so no real latch is built
    if (!active) begin
      d_in_d = 1'b0;
    end else if (hold_input) begin
      d_in_d = d_in_q;
    end else if (in_reg_sel) begin
      d_in_d = in_reg_q;
    end else if (frozen) begin
      d_in_d = d_in_q;
    end else begin
      d_in_d = pad_in;
    end
    pad_out_d = active ? (out_reg_sel ? out_reg_q : d_out) : 1'b0;
    pad_oe_d  = active ? (oe_reg_sel ? oe_reg_q : oe_core) : 1'b0;
    // Pull-up forced on until configured, then per-pin choice
    pull_d = configured ? (used & pullup_sel) : 1'b1;
  end

  // Register all state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_reg_q  <= 1'b0;
      out_reg_q <= 1'b0;
      oe_reg_q  <= 1'b0;
      d_in_q    <= 1'b0;
      pad_out_q <= 1'b0;
      pad_oe_q  <= 1'b0;
      pull_q    <= 1'b1;
    end else begin
      in_reg_q  <= in_reg_d;
      out_reg_q <= out_reg_d;
      oe_reg_q  <= oe_reg_d;
      d_in_q    <= d_in_d;
      pad_out_q <= pad_out_d;
      pad_oe_q  <= pad_oe_d;
      pull_q    <= pull_d;
    end
  end

  assign d_in       = d_in_q;
  assign pad_out    = pad_out_q;
  assign pad_oe     = pad_oe_q;
  assign pad_pullup = pull_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_preconfig_float: assert property (
    @(posedge pclk) disable iff (!presetn)
    !configured |=> (pad_pullup && !pad_oe))
    else $error("pin not floating with pull-up before config");

  a_unused_blocked: assert property (
    @(posedge pclk) disable iff (!presetn)
    (configured && !used) |=> (!d_in && !pad_pullup && !pad_oe))
    else $error("unused pin not blocked");

  a_freeze_holds: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active && !in_reg_sel && freeze && freeze_sel) |=> $stable(d_in))
    else $error("frozen input changed");

  a_hold_input: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active && hold_input) |=> $stable(d_in))
    else $error("held input changed");

  a_ce_keeps: assert property (
    @(posedge pclk) disable iff (!presetn)
    !clock_enable |=> ($stable(in_reg_q) && $stable(out_reg_q) &&
                       $stable(oe_reg_q)))
    else $error("register moved with clock enable low");

  a_in_sample: assert property (
    @(posedge pclk) disable iff (!presetn)
    (in_tick && clock_enable) |=> in_reg_q == $past(pad_in))
    else $error("input register missed its clock");

  a_out_bypass: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active && !out_reg_sel) |=> pad_out == $past(d_out))
    else $error("output bypass wrong");

  a_oe_follow: assert property (
    @(posedge pclk) disable iff (!presetn)
    (active && !oe_reg_sel) |=> pad_oe == $past(oe_core))
    else $error("output enable bypass wrong");

  a_pull_select: assert property (
    @(posedge pclk) disable iff (!presetn)
    (configured && used) |=> pad_pullup == $past(pullup_sel))
    else $error("pull-up select ignored");

endmodule

`default_nettype wire

/* File: logic/prog_io_cell.sv */
// Bank of programmable I/O cells with APB configuration registers
`default_nettype none

module prog_io_cell
  import prog_io_pkg::*;
(
  // APB slave
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [ADDR_W-1:0]   paddr,
  input  wire logic [DATA_W-1:0]   pwdata,
  input  wire logic [3:0]          pstrb,
  output logic                     pready,
  output logic [DATA_W-1:0]        prdata,
  output logic                     pslverr,
  // Core side
  input  wire logic                input_clk,
  input  wire logic                output_clk,
  input  wire logic                clock_enable,
  input  wire logic                latch_input_value,
  input  wire logic [NUM_PINS-1:0] d_out,
  input  wire logic [NUM_PINS-1:0] output_enable,
  output logic      [NUM_PINS-1:0] d_in,
  // Pad side
  input  wire logic [NUM_PINS-1:0] pad_in,
  output logic      [NUM_PINS-1:0] pad_out,
  output logic      [NUM_PINS-1:0] pad_oe,
  output logic      [NUM_PINS-1:0] pad_pullup
);

  // ----------------------------------------------------------------
  // Register clock edges
  // ----------------------------------------------------------------
  // The register clocks are sampled as inputs and turned into
  // one-cycle ticks; they must stay below half the pclk rate.
  logic in_clk_q, in_clk_d;
  logic out_clk_q, out_clk_d;
  logic in_tick;
  logic out_tick;

  // Edge detection of both register clocks, kept independent
  always_comb begin
    in_clk_d  = input_clk;
    out_clk_d = output_clk;
    in_tick   = input_clk & ~in_clk_q;
    out_tick  = output_clk & ~out_clk_q;
  end

  // Previous clock levels
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_clk_q  <= 1'b0;
      out_clk_q <= 1'b0;
    end else begin
      in_clk_q  <= in_clk_d;
      out_clk_q <= out_clk_d;
    end
  end

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  logic addr_ok;
  logic setup_ph;
  logic wr_en;

  // Only exact word offsets decode; anything else errors
  always_comb begin
    case (paddr)
      OFS_CTRL, OFS_USED, OFS_IN_SEL, OFS_OUT_SEL,
      OFS_OE_SEL, OFS_PULL, OFS_FRZ_SEL,
      OFS_PAD_IN, OFS_STATUS: addr_ok = 1'b1;
      default:                addr_ok = 1'b0;
    endcase
    setup_ph = psel & ~penable;
    // Zero wait states, so the access edge is the commit edge
    wr_en    = psel & penable & pwrite & pstrb[0] & addr_ok;
  end

  assign pready = 1'b1;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------
  cfg_phase_t          phase_q, phase_d;
  logic                freeze_q, freeze_d;
  logic [NUM_PINS-1:0] used_q, used_d;
  logic [NUM_PINS-1:0] in_sel_q, in_sel_d;
  logic [NUM_PINS-1:0] out_sel_q, out_sel_d;
  logic [NUM_PINS-1:0] oe_sel_q, oe_sel_d;
  logic [NUM_PINS-1:0] pull_q, pull_d;
  logic [NUM_PINS-1:0] frz_sel_q, frz_sel_d;
  logic [NUM_PINS-1:0] wbyte;

  // Register writes; the done flag can only be set, never cleared,
  // so a stray write cannot send pins back to the floating state
  always_comb begin
    wbyte     = pwdata[NUM_PINS-1:0];
    phase_d   = phase_q;
    freeze_d  = freeze_q;
    used_d    = used_q;
    in_sel_d  = in_sel_q;
    out_sel_d = out_sel_q;
    oe_sel_d  = oe_sel_q;
    pull_d    = pull_q;
    frz_sel_d = frz_sel_q;
    if (wr_en) begin
      case (paddr)
        OFS_CTRL: begin
          if (pwdata[CTRL_DONE_BIT]) begin
            phase_d = PH_USER;
          end
          freeze_d = pwdata[CTRL_FREEZE_BIT];
        end
        OFS_USED:    used_d    = wbyte;
        OFS_IN_SEL:  in_sel_d  = wbyte;
        OFS_OUT_SEL: out_sel_d = wbyte;
        OFS_OE_SEL:  oe_sel_d  = wbyte;
        OFS_PULL:    pull_d    = wbyte;
        OFS_FRZ_SEL: frz_sel_d = wbyte;
        default:     phase_d   = phase_q;
      endcase
    end
  end

  // Configuration state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_q   <= PH_PRECONFIG;
      freeze_q  <= 1'b0;
      used_q    <= RST_SEL;
      in_sel_q  <= RST_SEL;
      out_sel_q <= RST_SEL;
      oe_sel_q  <= RST_SEL;
      pull_q    <= RST_PULL;
      frz_sel_q <= RST_SEL;
    end else begin
      phase_q   <= phase_d;
      freeze_q  <= freeze_d;
      used_q    <= used_d;
      in_sel_q  <= in_sel_d;
      out_sel_q <= out_sel_d;
      oe_sel_q  <= oe_sel_d;
      pull_q    <= pull_d;
      frz_sel_q <= frz_sel_d;
    end
  end

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic              slverr_q, slverr_d;
  logic [DATA_W-1:0] rsel;

  // Read data is captured at the setup edge so that prdata comes
  // straight from a flop during the access phase
  always_comb begin
    rsel = '0;
    case (paddr)
      OFS_CTRL: begin
        rsel[CTRL_DONE_BIT]   = (phase_q == PH_USER);
        rsel[CTRL_FREEZE_BIT] = freeze_q;
      end
      OFS_USED:    rsel[NUM_PINS-1:0] = used_q;
      OFS_IN_SEL:  rsel[NUM_PINS-1:0] = in_sel_q;
      OFS_OUT_SEL: rsel[NUM_PINS-1:0] = out_sel_q;
      OFS_OE_SEL:  rsel[NUM_PINS-1:0] = oe_sel_q;
      OFS_PULL:    rsel[NUM_PINS-1:0] = pull_q;
      OFS_FRZ_SEL: rsel[NUM_PINS-1:0] = frz_sel_q;
      OFS_PAD_IN:  rsel[NUM_PINS-1:0] = pad_in;
      OFS_STATUS:  rsel[STAT_DONE_BIT] = (phase_q == PH_USER);
      default:     rsel = '0;
    endcase
    rdata_d  = rdata_q;
    slverr_d = slverr_q;
    if (setup_ph) begin
      rdata_d  = pwrite ? '0 : rsel;
      slverr_d = ~addr_ok;
    end
  end

  // Read data and error flops
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_q  <= '0;
      slverr_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  assign prdata  = rdata_q;
  assign pslverr = slverr_q & psel & penable;

  // ----------------------------------------------------------------
  // Cells
  // ----------------------------------------------------------------
  logic configured;

  assign configured = (phase_q == PH_USER);

  // One cell per pin; the bank freeze fans out to all of them
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      prog_io_pin u_pin (
        .pclk         (pclk),
        .presetn      (presetn),
        .configured   (configured),
        .used         (used_q[gi]),
        .in_reg_sel   (in_sel_q[gi]),
        .out_reg_sel  (out_sel_q[gi]),
        .oe_reg_sel   (oe_sel_q[gi]),
        .pullup_sel   (pull_q[gi]),
        .freeze_sel   (frz_sel_q[gi]),
        .freeze       (freeze_q),
        .hold_input   (latch_input_value),
        .in_tick      (in_tick),
        .out_tick     (out_tick),
        .clock_enable (clock_enable),
        .pad_in       (pad_in[gi]),
        .d_out        (d_out[gi]),
        .oe_core      (output_enable[gi]),
        .d_in         (d_in[gi]),
        .pad_out      (pad_out[gi]),
        .pad_oe       (pad_oe[gi]),
        .pad_pullup   (pad_pullup[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  a_config_gate: assert property (
    @(posedge pclk) disable iff (!presetn)
    (phase_q == PH_PRECONFIG) |-> (pad_oe == '0 && pad_pullup == '1))
    else $error("pins left preconfig state too early");

  a_phase_sticky: assert property (
    @(posedge pclk) disable iff (!presetn)
    (phase_q == PH_USER) |=> (phase_q == PH_USER))
    else $error("configured phase was lost");

  a_tick_single: assert property (
    @(posedge pclk) disable iff (!presetn)
    (in_tick || out_tick) |=> ((!in_tick || !$past(in_tick)) &&
                               (!out_tick || !$past(out_tick))))
    else $error("register clock tick longer than a cycle");

  a_bad_addr_err: assert property (
    @(posedge pclk) disable iff (!presetn)
    (setup_ph && !addr_ok) |=> (penable ? pslverr : 1'b1))
    else $error("unmapped access not flagged");

endmodule

`default_nettype wire

/* File: test/pad_model.sv */
// Pad and board source model facing the programmable I/O cell bank
`default_nettype none

module pad_model
  import prog_io_pkg::*;
(
  input  wire logic                pclk,
  input  wire logic [NUM_PINS-1:0] pad_out,
  input  wire logic [NUM_PINS-1:0] pad_oe,
  input  wire logic [NUM_PINS-1:0] pad_pullup,
  input  wire logic [NUM_PINS-1:0] ext_drive,
  input  wire logic [NUM_PINS-1:0] ext_val,
  output logic      [NUM_PINS-1:0] pad_level
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [NUM_PINS-1:0] float_q = 8'h55;

  // A floating pad toggles so a missing pull-up cannot pass unseen
  always @(posedge pclk) begin
    float_q <= ~float_q;
  end

  // Cell drive first, then the board source, then pull-up, else noise
  always_comb begin
    for (int i = 0; i < NUM_PINS; i++) begin
      if (pad_oe[i]) begin
        pad_level[i] = pad_out[i];
      end else if (ext_drive[i]) begin
        pad_level[i] = ext_val[i];
      end else begin
        pad_level[i] = pad_pullup[i] | float_q[i];
      end
    end
  end
endmodule

`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the programmable I/O cell bank
`default_nettype none

module tb_top
  import prog_io_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ----------------------------------------------------------------
  // Signals, clock and instances
  // ----------------------------------------------------------------
  logic                pclk, presetn, psel, penable, pwrite;
  logic [ADDR_W-1:0]   paddr;
  logic [DATA_W-1:0]   pwdata, prdata;
  logic [3:0]          pstrb;
  logic                pready, pslverr, input_clk, output_clk;
  logic                clock_enable, latch_input_value;
  logic [NUM_PINS-1:0] d_out, output_enable, d_in, pad_out, pad_oe;
  logic [NUM_PINS-1:0] pad_pullup, pad_level, ext_drive, ext_val;
  int                  miscompares, compares;

  // 50 ns period
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  prog_io_cell u_prog_io_cell (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .input_clk(input_clk), .output_clk(output_clk),
    .clock_enable(clock_enable), .latch_input_value(latch_input_value),
    .d_out(d_out), .output_enable(output_enable), .d_in(d_in),
    .pad_in(pad_level), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup)
  );

  pad_model u_pad_model (
    .pclk(pclk), .pad_out(pad_out), .pad_oe(pad_oe),
    .pad_pullup(pad_pullup), .ext_drive(ext_drive), .ext_val(ext_val),
    .pad_level(pad_level)
  );

  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic chk_pin(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Request held until pready is seen high; data taken at that edge
  task automatic apb(input logic wr_n, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= wr_n;
    paddr  <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x,
                        input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    chk_reg(r, x);
    chk_pin({7'h00, e}, {7'h00, xe});
  endtask

  // Steady-state wait; outputs do not move at the sampling edge
  task automatic wt;
    repeat (4) @(posedge pclk);
  endtask

  // One pulse on a register clock, high for two bus clocks
  task automatic tick(input logic o);
    @(posedge pclk);
    if (o) begin
      output_clk <= 1'b1;
    end else begin
      input_clk <= 1'b1;
    end
    repeat (2) @(posedge pclk);
    output_clk <= 1'b0;
    input_clk  <= 1'b0;
    wt();
  endtask

  task automatic stop_test;
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Tests
  // ----------------------------------------------------------------
  // Hang guard: the sequence needs well under a thousand cycles
  initial begin
    repeat (3000) @(posedge pclk);
    miscompares++;
    stop_test();
  end

  initial begin
    {presetn, psel, penable, pwrite, input_clk, output_clk} = 6'h00;
    {clock_enable, latch_input_value} = 2'b00;
    {paddr, pwdata, pstrb} = {8'h00, 32'h0000_0000, 4'hF};
    {d_out, output_enable, ext_drive, ext_val} = 32'h0000_0000;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    // User settings written early must not show before configuration
    wr(OFS_USED, 32'h0000_00FF);
    d_out <= 8'hFF;
    output_enable <= 8'hFF;
    wt();
    chk_pin(pad_oe, 8'h00);
    chk_pin(pad_pullup, 8'hFF);
    chk_pin(pad_level, 8'hFF);
    chk_pin(d_in, 8'h00);
    rd_chk(OFS_STATUS, 32'h0, 1'b0);
    rd_chk(OFS_PULL, 32'hFF, 1'b0);
    rd_chk(8'h40, 32'h0, 1'b1);
    // A write with the low byte strobe off is dropped
    pstrb <= 4'h0;
    wr(OFS_PULL, 32'h0000_0000);
    pstrb <= 4'hF;
    rd_chk(OFS_PULL, 32'hFF, 1'b0);
    // Configure with the upper four pins unused
    wr(OFS_USED, 32'h0000_000F);
    wr(OFS_PULL, 32'h0000_0005);
    output_enable <= 8'h00;
    ext_drive <= 8'hFF;
    ext_val <= 8'hA5;
    wr(OFS_CTRL, 32'h0000_0001);
    wt();
    chk_pin(pad_pullup, 8'h05);
    chk_pin(d_in, 8'h05);
    rd_chk(OFS_STATUS, 32'h1, 1'b0);
    rd_chk(OFS_PAD_IN, 32'hA5, 1'b0);
    // Unregistered output and enable, high nibble read back via pads
    wr(OFS_USED, 32'h0000_00FF);
    d_out <= 8'h3C;
    output_enable <= 8'hF0;
    wt();
    chk_pin(pad_out, 8'h3C);
    chk_pin(pad_oe, 8'hF0);
    chk_pin(d_in, 8'h35);
    // Registered output and enable
    wr(OFS_OUT_SEL, 32'h0000_00FF);
    wr(OFS_OE_SEL, 32'h0000_00FF);
    d_out <= 8'hC3;
    output_enable <= 8'hFF;
    clock_enable <= 1'b1;
    tick(1'b1);
    chk_pin(pad_out, 8'hC3);
    chk_pin(pad_oe, 8'hFF);
    d_out <= 8'h00;
    output_enable <= 8'h00;
    clock_enable <= 1'b0;
    tick(1'b1);
    chk_pin(pad_out, 8'hC3);
    clock_enable <= 1'b1;
    tick(1'b0);
    chk_pin(pad_oe, 8'hFF);
    tick(1'b1);
    chk_pin(pad_oe, 8'h00);
    chk_pin(pad_out, 8'h00);
    // Registered input, then clock enable off, then freeze ignored
    wr(OFS_IN_SEL, 32'h0000_00FF);
    ext_val <= 8'h5A;
    tick(1'b0);
    chk_pin(d_in, 8'h5A);
    ext_val <= 8'hA5;
    clock_enable <= 1'b0;
    tick(1'b0);
    chk_pin(d_in, 8'h5A);
    clock_enable <= 1'b1;
    tick(1'b1);
    chk_pin(d_in, 8'h5A);
    wr(OFS_FRZ_SEL, 32'h0000_00FF);
    wr(OFS_CTRL, 32'h0000_0003);
    tick(1'b0);
    chk_pin(d_in, 8'hA5);
    // Bank freeze on the low nibble of unregistered inputs
    wr(OFS_CTRL, 32'h0000_0001);
    wr(OFS_IN_SEL, 32'h0000_0000);
    wr(OFS_FRZ_SEL, 32'h0000_000F);
    ext_val <= 8'h5A;
    wt();
    chk_pin(d_in, 8'h5A);
    wr(OFS_CTRL, 32'h0000_0003);
    ext_val <= 8'hA5;
    wt();
    chk_pin(d_in, 8'hAA);
    wr(OFS_CTRL, 32'h0000_0001);
    wt();
    chk_pin(d_in, 8'hA5);
    // Hold input keeps every pin
    latch_input_value <= 1'b1;
    ext_val <= 8'h3C;
    wt();
    chk_pin(d_in, 8'hA5);
    latch_input_value <= 1'b0;
    wt();
    chk_pin(d_in, 8'h3C);
    // Reset in mid-run must bring every pin back to the floating state
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    chk_pin(pad_oe, 8'h00);
    chk_pin(pad_pullup, 8'hFF);
    presetn <= 1'b1;
    wt();
    chk_pin(d_in, 8'h00);
    chk_pin(pad_oe, 8'h00);
    rd_chk(OFS_CTRL, 32'h0, 1'b0);
    rd_chk(OFS_USED, 32'h0, 1'b0);
    stop_test();
  end
endmodule

`default_nettype wire
